// ==== eeprom_config_loader.sv ====
// Two-wire EEPROM configuration loader, top level
`default_nettype none
`include "eeprom_config_loader_cfg.svh"
module eeprom_config_loader
	import eeprom_config_loader_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        eeLinkClk,
	output logic             sclOut,
	output logic             sclOeN,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOeN,
	input  wire logic [63:0] strapPortSetup,
	input  wire logic [15:0] strapMacSetup,
	input  wire logic [7:0]  strapTrunkSetup,
	input  wire logic [7:0]  strapGeneralSetup,
	input  wire logic [7:0]  anegFcAbility,
	output logic             configValid,
	output logic             loadFailed,
	output logic [15:0]      validityMask,
	output logic [15:0]      pauseTimeValue,
	output logic [15:0]      macSetup,
	output logic [7:0]       trunkSetup,
	output logic [7:0]       generalSetup,
	output logic [7:0]       eeDuplexSpeedSel,
	output logic [7:0]       portFullDuplex,
	output logic [7:0]       port100Mb,
	output logic [7:0]       portFcEnable,
	output logic [7:0]       portPrecedenceForce
);
	logic        rstMeta_q;
	logic        rstN_q;
	logic        linkRstMeta_q;
	logic        linkRstN;
	logic        sdaMeta_q;
	logic        sdaSync_q;
	logic        ackMeta_q;
	logic        ackSync_q;
	logic        reqMeta_q;
	logic        reqSync_q;
	logic        reqSeen_q;
	logic        doneMeta_q;
	logic        doneSync_q;
	logic        failMeta_q;
	logic        failSync_q;
	logic [2:0]  qCnt_q;
	logic [1:0]  phase_q;
	logic        tick;
	logic        sampleNow;
	logic        bitEnd;
	link_state_t state_q;
	read_step_t  step_q;
	logic [3:0]  bitCnt_q;
	logic [7:0]  shift_q;
	logic [7:0]  rx_q;
	logic [3:0]  addr_q;
	logic        lastSda_q;
	logic        reqTgl_q;
	logic        fail_q;
	logic        done_q;
	logic        sclRel;
	logic        sdaRel;
	logic        sclOeN_q;
	logic        sdaOeN_q;

	config_load_if cfgBus ();

	// Reset release, core side
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstMeta_q <= 1'b0;
			rstN_q    <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstN_q    <= rstMeta_q;
		end
	end

	// Reset release, link side
	always_ff @(posedge eeLinkClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			linkRstMeta_q <= 1'b0;
			linkRstN      <= 1'b0;
		end
		else
		begin
			linkRstMeta_q <= 1'b1;
			linkRstN      <= linkRstMeta_q;
		end
	end

	// Data pin and returning acknowledge toggle
	always_ff @(posedge eeLinkClk or negedge linkRstN)
	begin
		if (!linkRstN)
		begin
			sdaMeta_q <= 1'b1;
			sdaSync_q <= 1'b1;
			ackMeta_q <= 1'b0;
			ackSync_q <= 1'b0;
		end
		else
		begin
			sdaMeta_q <= sdaIn;
			sdaSync_q <= sdaMeta_q;
			ackMeta_q <= reqSeen_q;
			ackSync_q <= ackMeta_q;
		end
	end

	// Quarter-bit timing
	always_ff @(posedge eeLinkClk or negedge linkRstN)
	begin
		if (!linkRstN)
		begin
			qCnt_q  <= 3'h0;
			phase_q <= 2'h0;
		end
		else if (tick)
		begin
			qCnt_q  <= 3'h0;
			phase_q <= phase_q + 2'h1;
		end
		else
			qCnt_q <= qCnt_q + 3'h1;
	end

	assign tick = qCnt_q == `QUARTER_LAST;
	assign sampleNow = tick && (phase_q == 2'h1);
	assign bitEnd = tick && (phase_q == 2'h3);

	// Bus sequence
	always_ff @(posedge eeLinkClk or negedge linkRstN)
	begin
		if (!linkRstN)
			state_q <= ST_RECOVER;
		else if (bitEnd)
		begin
			unique case (state_q)
				ST_RECOVER:
					if (lastSda_q || bitCnt_q == `RECOVER_LAST)
						state_q <= ST_START;
				ST_START:
					state_q <= ST_TXBIT;
				ST_TXBIT:
					if (bitCnt_q == `BIT_LAST)
						state_q <= ST_ACK;
				ST_ACK:
					if (lastSda_q)
						state_q <= ST_STOP;
					else if (step_q == STEP_WORD)
						state_q <= ST_START;
					else if (step_q == STEP_DEV_RD)
						state_q <= ST_RXBIT;
					else
						state_q <= ST_TXBIT;
				ST_RXBIT:
					if (bitCnt_q == `BIT_LAST)
						state_q <= ST_NACK;
				ST_NACK:
					state_q <= ST_STOP;
				ST_STOP:
					state_q <= fail_q ? ST_DONE : ST_HANDOFF;
				ST_HANDOFF:
					if (ackSync_q == reqTgl_q)
						state_q <= (addr_q == `EE_LAST_ADDR) ? ST_DONE : ST_START;
				ST_DONE:
					state_q <= ST_DONE;
				default:
					state_q <= ST_RECOVER;
			endcase
		end
	end

	// Bit counting, shifting and address stepping
	always_ff @(posedge eeLinkClk or negedge linkRstN)
	begin
		if (!linkRstN)
		begin
			bitCnt_q <= 4'h0;
			step_q   <= STEP_DEV_WR;
			shift_q  <= 8'hff;
			addr_q   <= 4'h0;
		end
		else if (bitEnd)
		begin
			unique case (state_q)
				ST_RECOVER, ST_TXBIT, ST_RXBIT:
				begin
					bitCnt_q <= bitCnt_q + 4'h1;
					shift_q  <= {shift_q[6:0], 1'b1};
				end
				ST_START:
				begin
					bitCnt_q <= 4'h0;
					shift_q  <= {`EE_DEV_ADDR, step_q == STEP_DEV_RD};
				end
				ST_ACK:
				begin
					bitCnt_q <= 4'h0;
					if (step_q == STEP_DEV_WR)
					begin
						step_q  <= STEP_WORD;
						shift_q <= {4'h0, addr_q};
					end
					else if (step_q == STEP_WORD)
						step_q <= STEP_DEV_RD;
				end
				ST_HANDOFF:
					if (ackSync_q == reqTgl_q && addr_q != `EE_LAST_ADDR)
					begin
						step_q <= STEP_DEV_WR;
						addr_q <= addr_q + 4'h1;
					end
				ST_NACK, ST_STOP, ST_DONE:
					bitCnt_q <= 4'h0;
				default:
					bitCnt_q <= 4'h0;
			endcase
		end
	end

	// Sampling of the data line
	always_ff @(posedge eeLinkClk or negedge linkRstN)
	begin
		if (!linkRstN)
		begin
			lastSda_q <= 1'b0;
			rx_q      <= 8'h0;
		end
		else if (sampleNow)
		begin
			lastSda_q <= sdaSync_q;
			if (state_q == ST_RXBIT)
				rx_q <= {rx_q[6:0], sdaSync_q};
		end
	end

	// Load status and byte handoff toggle
	always_ff @(posedge eeLinkClk or negedge linkRstN)
	begin
		if (!linkRstN)
		begin
			reqTgl_q <= 1'b0;
			fail_q   <= 1'b0;
			done_q   <= 1'b0;
		end
		else if (bitEnd)
		begin
			if (state_q == ST_ACK && lastSda_q)
				fail_q <= 1'b1;
			if (state_q == ST_STOP && !fail_q)
				reqTgl_q <= !reqTgl_q;
			if ((state_q == ST_STOP && fail_q) || (state_q == ST_HANDOFF
				&& ackSync_q == reqTgl_q && addr_q == `EE_LAST_ADDR))
				done_q <= 1'b1;
		end
	end

	// Pin levels per state and quarter
	always_comb
	begin
		sclRel = phase_q[0] ^ phase_q[1];
		sdaRel = 1'b1;
		unique case (state_q)
			ST_RECOVER, ST_ACK, ST_RXBIT, ST_NACK:
				sdaRel = 1'b1;
			ST_START:
				sdaRel = !phase_q[1];
			ST_TXBIT:
				sdaRel = shift_q[7];
			ST_STOP:
			begin
				sclRel = phase_q != 2'h0;
				sdaRel = phase_q[1];
			end
			ST_HANDOFF, ST_DONE:
				sclRel = 1'b1;
			default:
				sdaRel = 1'b1;
		endcase
	end

	always_ff @(posedge eeLinkClk or negedge linkRstN)
	begin
		if (!linkRstN)
		begin
			sclOeN_q <= 1'b1;
			sdaOeN_q <= 1'b1;
		end
		else
		begin
			sclOeN_q <= sclRel;
			sdaOeN_q <= sdaRel;
		end
	end

	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOeN = sclOeN_q;
	assign sdaOeN = sdaOeN_q;

	// Core side of the handoff
	always_ff @(posedge ref_clk or negedge rstN_q)
	begin
		if (!rstN_q)
		begin
			reqMeta_q  <= 1'b0;
			reqSync_q  <= 1'b0;
			reqSeen_q  <= 1'b0;
			doneMeta_q <= 1'b0;
			doneSync_q <= 1'b0;
			failMeta_q <= 1'b0;
			failSync_q <= 1'b0;
		end
		else
		begin
			reqMeta_q  <= reqTgl_q;
			reqSync_q  <= reqMeta_q;
			reqSeen_q  <= reqSync_q;
			doneMeta_q <= done_q;
			doneSync_q <= doneMeta_q;
			failMeta_q <= fail_q;
			failSync_q <= failMeta_q;
		end
	end

	assign cfgBus.wrStb = reqSync_q ^ reqSeen_q;
	assign cfgBus.wrAddr = addr_q;
	assign cfgBus.wrData = rx_q;
	assign cfgBus.loadDone = doneSync_q;
	assign cfgBus.loadFail = failSync_q;

	eeprom_config_store store (
		.ref_clk             (ref_clk),
		.rstN                (rstN_q),
		.io                  (cfgBus.store),
		.strapPortSetup      (strapPortSetup),
		.strapMacSetup       (strapMacSetup),
		.strapTrunkSetup     (strapTrunkSetup),
		.strapGeneralSetup   (strapGeneralSetup),
		.anegFcAbility       (anegFcAbility),
		.configValid         (configValid),
		.loadFailed          (loadFailed),
		.validityMask        (validityMask),
		.pauseTimeValue      (pauseTimeValue),
		.macSetup            (macSetup),
		.trunkSetup          (trunkSetup),
		.generalSetup        (generalSetup),
		.eeDuplexSpeedSel    (eeDuplexSpeedSel),
		.portFullDuplex      (portFullDuplex),
		.port100Mb           (port100Mb),
		.portFcEnable        (portFcEnable),
		.portPrecedenceForce (portPrecedenceForce)
	);

	sequence seqRxDone;
		state_q == ST_RXBIT ##1 state_q == ST_NACK;
	endsequence

	sequence seqNackLeft;
		state_q == ST_NACK ##1 state_q != ST_NACK;
	endsequence

	a_start_only: assert property (@(posedge eeLinkClk) disable iff (!linkRstN)
		$fell(sdaOeN_q) && sclOeN_q && $past(sclOeN_q) |-> $past(state_q) == ST_START)
		else $error("Data fell with clock high outside start");
	a_stop_only: assert property (@(posedge eeLinkClk) disable iff (!linkRstN)
		$rose(sdaOeN_q) && sclOeN_q && $past(sclOeN_q) |-> $past(state_q) == ST_STOP)
		else $error("Data rose with clock high outside stop");
	a_float_reset: assert property (@(posedge eeLinkClk) disable iff (!linkRstN)
		$rose(linkRstN) |-> sclOeN_q && sdaOeN_q && state_q == ST_RECOVER)
		else $error("Pins driven or no recovery at reset release");
	a_recover_limit: assert property (@(posedge eeLinkClk) disable iff (!linkRstN)
		state_q == ST_RECOVER |-> bitCnt_q <= 4'h8)
		else $error("Recovery ran past nine clocks");
	a_ack_release: assert property (@(posedge eeLinkClk) disable iff (!linkRstN)
		state_q == ST_ACK && $past(state_q) == ST_ACK |-> sdaOeN_q)
		else $error("Data driven during acknowledge clock");
	a_nack_release: assert property (@(posedge eeLinkClk) disable iff (!linkRstN)
		seqRxDone |=> sdaOeN_q [*8])
		else $error("Read byte acknowledged by master");
	a_nack_stop: assert property (@(posedge eeLinkClk) disable iff (!linkRstN)
		seqNackLeft |-> state_q == ST_STOP)
		else $error("No stop after read byte");
	a_read_dir: assert property (@(posedge eeLinkClk) disable iff (!linkRstN)
		state_q == ST_TXBIT && step_q != STEP_WORD && bitCnt_q == 4'h7
		|-> shift_q[7] == (step_q == STEP_DEV_RD))
		else $error("Wrong direction bit in device address");
	a_word_addr: assert property (@(posedge eeLinkClk) disable iff (!linkRstN)
		$rose(state_q == ST_TXBIT) && step_q == STEP_WORD |-> shift_q == {4'h0, addr_q})
		else $error("Word address does not match load position");
	a_handoff_hold: assert property (@(posedge eeLinkClk) disable iff (!linkRstN)
		state_q == ST_HANDOFF |-> $stable(rx_q) && $stable(addr_q))
		else $error("Handoff data changed while pending");
	a_strobe_pulse: assert property (@(posedge ref_clk) disable iff (!rstN_q)
		cfgBus.wrStb |=> !cfgBus.wrStb)
		else $error("Write strobe longer than one cycle");
endmodule // eeprom_config_loader
`default_nettype wire

// ==== eeprom_config_loader_cfg.svh ====
// Constants for the EEPROM configuration loader
`ifndef EEPROM_CONFIG_LOADER_CFG_SVH
`define EEPROM_CONFIG_LOADER_CFG_SVH
`define EE_DEV_ADDR    7'h50
`define EE_LAST_ADDR   4'hf
`define OFS_VALID_HI   4'h0
`define OFS_VALID_LO   4'h1
`define OFS_PAUSE_HI   4'h2
`define OFS_PAUSE_LO   4'h3
`define OFS_PORT0      4'h4
`define OFS_MAC_HI     4'hc
`define OFS_MAC_LO     4'hd
`define OFS_TRUNK      4'he
`define OFS_GENERAL    4'hf
`define VB_PAUSE       0
`define VB_PORT0       1
`define VB_MAC         9
`define VB_TRUNK       10
`define VB_GENERAL     11
`define PAUSE_RESET    16'h0600
`define MODE_EEPROM    2'h2
`define FCOPT_BIT      8
`define QUARTER_LAST   3'h4
`define RECOVER_LAST   4'h8
`define BIT_LAST       4'h7
`endif

// ==== eeprom_config_loader_pkg.sv ====
// Types for the EEPROM configuration loader
`default_nettype none
package eeprom_config_loader_pkg;
	typedef enum logic [3:0] {
		ST_RECOVER = 4'b0000,
		ST_START   = 4'b0001,
		ST_TXBIT   = 4'b0010,
		ST_ACK     = 4'b0011,
		ST_RXBIT   = 4'b0100,
		ST_NACK    = 4'b0101,
		ST_STOP    = 4'b0110,
		ST_HANDOFF = 4'b0111,
		ST_DONE    = 4'b1000
	} link_state_t;
	typedef enum logic [1:0] {
		STEP_DEV_WR = 2'b00,
		STEP_WORD   = 2'b01,
		STEP_DEV_RD = 2'b10
	} read_step_t;
	typedef struct packed {
		logic [1:0] mode;
		logic       fullDuplex;
		logic       speed100;
		logic       fdPauseFrameDisable;
		logic       portPrecedenceForce;
		logic [1:0] unused;
	} port_setup_t;
endpackage
`default_nettype wire

// ==== config_load_if.sv ====
// Carrier for loaded bytes and load status between loader and store
`default_nettype none
interface config_load_if;
	logic       wrStb;
	logic [3:0] wrAddr;
	logic [7:0] wrData;
	logic       loadDone;
	logic       loadFail;
	modport loader (output wrStb, wrAddr, wrData, loadDone, loadFail);
	modport store  (input wrStb, wrAddr, wrData, loadDone, loadFail);
endinterface
`default_nettype wire

// ==== eeprom_config_store.sv ====
// Holds loaded configuration and applies validity gating
`default_nettype none
`include "eeprom_config_loader_cfg.svh"
module eeprom_config_store
	import eeprom_config_loader_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstN,
	config_load_if.store     io,
	input  wire logic [63:0] strapPortSetup,
	input  wire logic [15:0] strapMacSetup,
	input  wire logic [7:0]  strapTrunkSetup,
	input  wire logic [7:0]  strapGeneralSetup,
	input  wire logic [7:0]  anegFcAbility,
	output logic             configValid,
	output logic             loadFailed,
	output logic [15:0]      validityMask,
	output logic [15:0]      pauseTimeValue,
	output logic [15:0]      macSetup,
	output logic [7:0]       trunkSetup,
	output logic [7:0]       generalSetup,
	output logic [7:0]       eeDuplexSpeedSel,
	output logic [7:0]       portFullDuplex,
	output logic [7:0]       port100Mb,
	output logic [7:0]       portFcEnable,
	output logic [7:0]       portPrecedenceForce
);
	logic [103:0] pinMeta_q;
	logic [103:0] pinSync_q;
	logic [15:0]  mask_q;
	logic [15:0]  pause_q;
	logic [7:0]   port_q [8];
	logic [15:0]  mac_q;
	logic [7:0]   trunk_q;
	logic [7:0]   general_q;
	logic [11:0]  validEff;
	logic [15:0]  macEff;
	port_setup_t  portEff [8];

	// Strap pins
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			pinMeta_q <= 104'h0;
			pinSync_q <= 104'h0;
		end
		else
		begin
			pinMeta_q <= {anegFcAbility, strapGeneralSetup, strapTrunkSetup,
				strapMacSetup, strapPortSetup};
			pinSync_q <= pinMeta_q;
		end
	end

	// Loaded bytes
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			mask_q    <= 16'h0;
			pause_q   <= `PAUSE_RESET;
			mac_q     <= 16'h0;
			trunk_q   <= 8'h0;
			general_q <= 8'h0;
			for (int n = 0; n < 8; n++)
				port_q[n] <= 8'h0;
		end
		else if (io.wrStb)
		begin
			for (int n = 0; n < 8; n++)
				if (io.wrAddr == 4'(`OFS_PORT0 + n))
					port_q[n] <= io.wrData;
			case (io.wrAddr)
				`OFS_VALID_HI: mask_q[15:8] <= io.wrData;
				`OFS_VALID_LO: mask_q[7:0] <= io.wrData;
				`OFS_PAUSE_HI: pause_q[15:8] <= io.wrData;
				`OFS_PAUSE_LO: pause_q[7:0] <= io.wrData;
				`OFS_MAC_HI: mac_q[15:8] <= io.wrData;
				`OFS_MAC_LO: mac_q[7:0] <= io.wrData;
				`OFS_TRUNK: trunk_q <= io.wrData;
				`OFS_GENERAL: general_q <= io.wrData;
				default: ;
			endcase
		end
	end

	// Effective settings
	always_comb
	begin
		validEff = (io.loadDone && !io.loadFail) ? mask_q[11:0] : 12'h0;
		macEff = validEff[`VB_MAC] ? mac_q : pinSync_q[79:64];
		for (int n = 0; n < 8; n++)
			portEff[n] = validEff[`VB_PORT0 + n] ? port_setup_t'(port_q[n])
				: port_setup_t'(pinSync_q[8*n +: 8]);
	end

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			configValid         <= 1'b0;
			loadFailed          <= 1'b0;
			validityMask        <= 16'h0;
			pauseTimeValue      <= `PAUSE_RESET;
			macSetup            <= 16'h0;
			trunkSetup          <= 8'h0;
			generalSetup        <= 8'h0;
			eeDuplexSpeedSel    <= 8'h0;
			portFullDuplex      <= 8'h0;
			port100Mb           <= 8'h0;
			portFcEnable        <= 8'h0;
			portPrecedenceForce <= 8'h0;
		end
		else
		begin
			configValid <= io.loadDone;
			loadFailed <= io.loadFail;
			validityMask <= {4'h0, validEff};
			pauseTimeValue <= validEff[`VB_PAUSE] ? pause_q : `PAUSE_RESET;
			macSetup <= macEff;
			trunkSetup <= validEff[`VB_TRUNK] ? trunk_q : pinSync_q[87:80];
			generalSetup <= validEff[`VB_GENERAL] ? general_q : pinSync_q[95:88];
			for (int n = 0; n < 8; n++)
			begin
				eeDuplexSpeedSel[n] <= portEff[n].mode == `MODE_EEPROM;
				portFullDuplex[n] <= (portEff[n].mode == `MODE_EEPROM)
					&& portEff[n].fullDuplex;
				port100Mb[n] <= (portEff[n].mode == `MODE_EEPROM) && portEff[n].speed100;
				portFcEnable[n] <= validEff[`VB_PORT0 + n] ? !portEff[n].fdPauseFrameDisable
					: (!macEff[`FCOPT_BIT] || pinSync_q[96 + n]);
				portPrecedenceForce[n] <= portEff[n].portPrecedenceForce;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstN);

	a_valid_wait: assert property (!io.loadDone |=> !configValid)
		else $error("Configuration marked valid before load ended");
	a_pause_default: assert property (!validEff[0] |=> pauseTimeValue == 16'h0600)
		else $error("Pause time not at default while unvalidated");
	a_fc_eeprom: assert property (validEff[1] |=> portFcEnable[0] == !$past(port_q[0][3]))
		else $error("Loaded flow-control setting not applied");
	a_port_gate: assert property (!validEff[8] |=> portPrecedenceForce[7] == $past(pinSync_q[58]))
		else $error("Unvalidated port byte used");
endmodule // eeprom_config_store
`default_nettype wire

// ==== eeprom_partner.sv ====
// Behavioural two-wire configuration memory on the far side of the loader
`default_nettype none
`include "eeprom_config_loader_cfg.svh"
module eeprom_partner (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic present,
	output logic      pullLow
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [7:0] sh;
	logic [7:0] ptr;
	int         bitN;
	int         nByte;
	int         k;
	logic       act = 1'b0;
	logic       tx = 1'b0;
	logic       busy = 1'b0;
	initial
		pullLow = 1'b0;
	// Start or repeated start restarts word framing
	always @(negedge sda)
	begin
		if (scl && present && !busy)
		begin
			act = 1'b1;
			tx = 1'b0;
			bitN = 0;
			nByte = 0;
			k = 0;
		end
	end
	// Stop returns the memory to standby
	always @(posedge sda)
	begin
		if (scl)
		begin
			if (act && !tx && nByte > 2)
				busy = 1'b1;
			act = 1'b0;
		end
	end
	// Internal write cycle ignores the bus until it ends
	always @(posedge busy)
	begin
		#5000;
		busy = 1'b0;
	end
	always @(posedge scl)
	begin
		if (act && !tx && bitN < 8)
		begin
			sh = {sh[6:0], sda};
			bitN++;
		end
	end
	// Line changes only after the clock falls
	always @(negedge scl)
	begin
		if (act && bitN == 9)
		begin
			pullLow = 1'b0;
			bitN = 0;
			if (nByte == 0 && sh[0])
			begin
				tx = 1'b1;
				sh = mem[ptr];
			end
			else if (nByte == 1)
				ptr = sh;
			nByte++;
		end
		if (act && bitN == 8)
		begin
			pullLow = nByte > 0 || sh[7:1] == `EE_DEV_ADDR;
			bitN = 9;
		end
		if (act && tx)
		begin
			pullLow = k < 8 && !sh[7 - k];
			k++;
		end
	end
endmodule // eeprom_partner
`default_nettype wire

// ==== eeprom_config_loader_bench.sv ====
// Self-checking bench for the EEPROM configuration loader
`default_nettype none
`include "eeprom_config_loader_cfg.svh"
module eeprom_config_loader_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic        fail;
		logic [15:0] mask;
		logic [15:0] pause;
		logic [15:0] mac;
		logic [7:0]  trunk;
		logic [7:0]  gen;
		logic [7:0]  sel;
		logic [7:0]  fd;
		logic [7:0]  sp;
		logic [7:0]  fc;
		logic [7:0]  prec;
	} exp_t;
	logic        ref_clk = 1'b0;
	logic        eeLinkClk = 1'b0;
	logic        arst_n = 1'b0;
	logic        present = 1'b0;
	logic [63:0] strapPortSetup = 64'h0;
	logic [15:0] strapMacSetup = 16'h0;
	logic [7:0]  strapTrunkSetup = 8'h0;
	logic [7:0]  strapGeneralSetup = 8'h0;
	logic [7:0]  anegFcAbility = 8'h0;
	logic        sclOut, sclOeN, sdaOut, sdaOeN, configValid, loadFailed, pullLow;
	logic [15:0] validityMask, pauseTimeValue, macSetup;
	logic [7:0]  trunkSetup, generalSetup, eeDuplexSpeedSel, portFullDuplex;
	logic [7:0]  port100Mb, portFcEnable, portPrecedenceForce;
	wire         sclW;
	wire         sdaW;
	int          miscompares = 0;
	int          nTests = 0;
	exp_t        notes[$];
	// Open-drain wires with pull-ups
	assign sclW = sclOeN ? 1'b1 : sclOut;
	assign sdaW = (sdaOeN ? 1'b1 : sdaOut) & ~pullLow;
	always #5 ref_clk = ~ref_clk;
	initial
	begin
		#3.3;
		forever #62.5 eeLinkClk = ~eeLinkClk;
	end
	eeprom_config_loader DUT (.ref_clk, .arst_n, .eeLinkClk, .sclOut, .sclOeN, .sdaIn(sdaW),
		.sdaOut, .sdaOeN, .strapPortSetup, .strapMacSetup, .strapTrunkSetup,
		.strapGeneralSetup, .anegFcAbility, .configValid, .loadFailed, .validityMask,
		.pauseTimeValue, .macSetup, .trunkSetup, .generalSetup, .eeDuplexSpeedSel,
		.portFullDuplex, .port100Mb, .portFcEnable, .portPrecedenceForce);
	eeprom_partner ee (.scl(sclW), .sda(sdaW), .present, .pullLow);
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		nTests++;
		if (seen !== want)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic tallyAndFinish();
		$display("Comparisons %0d, mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic doReset();
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (8) @(posedge eeLinkClk);
		check(sclOeN, 1'b1);
		check(sdaOeN, 1'b1);
		@(posedge ref_clk);
		arst_n <= 1'b1;
	endtask
	// Fills memory and straps, notes the expected configuration
	task automatic prepare(input logic [15:0] mask, input logic pres);
		exp_t        e;
		logic [63:0] s;
		logic [15:0] sm;
		logic [7:0]  st, sg, an, b;
		logic        v;
		s = {$urandom, $urandom};
		sm = 16'($urandom);
		st = 8'($urandom);
		sg = 8'($urandom);
		an = 8'($urandom);
		for (int i = 0; i < 256; i++)
			ee.mem[i] = 8'($urandom);
		ee.mem[0] = mask[15:8];
		ee.mem[1] = mask[7:0];
		for (int n = 0; n < 8; n++)
			ee.mem[4 + n][7:6] = 2'(n) + mask[1:0];
		@(posedge ref_clk);
		present <= pres;
		strapPortSetup <= s;
		strapMacSetup <= sm;
		strapTrunkSetup <= st;
		strapGeneralSetup <= sg;
		anegFcAbility <= an;
		e.fail = !pres;
		e.mask = pres ? {4'h0, mask[11:0]} : 16'h0;
		e.pause = pres && mask[`VB_PAUSE] ? {ee.mem[2], ee.mem[3]} : `PAUSE_RESET;
		e.mac = pres && mask[`VB_MAC] ? {ee.mem[12], ee.mem[13]} : sm;
		e.trunk = pres && mask[`VB_TRUNK] ? ee.mem[14] : st;
		e.gen = pres && mask[`VB_GENERAL] ? ee.mem[15] : sg;
		for (int n = 0; n < 8; n++)
		begin
			v = pres && mask[n + 1];
			b = v ? ee.mem[4 + n] : s[8 * n +: 8];
			e.sel[n] = b[7:6] == `MODE_EEPROM;
			e.fd[n] = b[5] & e.sel[n];
			e.sp[n] = b[4] & e.sel[n];
			e.fc[n] = v ? !b[3] : !e.mac[`FCOPT_BIT] || an[n];
			e.prec[n] = b[2];
		end
		notes.push_back(e);
	endtask
	task automatic waitDone();
		int n;
		n = 0;
		while (configValid !== 1'b1 && n < 250000)
		begin
			@(posedge ref_clk);
			n++;
		end
		check(configValid, 1'b1);
		repeat (5) @(posedge ref_clk);
	endtask
	// Compares the oldest note once a load completes
	always @(posedge configValid)
	begin
		exp_t e;
		@(posedge ref_clk);
		#1;
		check(16'(notes.size()), 16'h1);
		e = notes.pop_front();
		check(sdaW, 1'b1);
		check(sclOut, 1'b0);
		check(sdaOut, 1'b0);
		check(loadFailed, e.fail);
		check(validityMask, e.mask);
		check(pauseTimeValue, e.pause);
		check(macSetup, e.mac);
		check(trunkSetup, e.trunk);
		check(generalSetup, e.gen);
		check(eeDuplexSpeedSel, e.sel);
		check(portFullDuplex, e.fd);
		check(port100Mb, e.sp);
		check(portFcEnable, e.fc);
		check(portPrecedenceForce, e.prec);
	end
	initial
	begin
		#8_000_000;
		miscompares++;
		tallyAndFinish();
	end
	initial
	begin
		logic [15:0] m;
		void'($urandom(32'h6c8b));
		m = 16'($urandom);
		prepare(m, 1'b1);
		doReset();
		repeat (30000) @(posedge ref_clk);
		check(configValid, 1'b0);
		check(validityMask, 16'h0);
		doReset();
		waitDone();
		prepare(~m, 1'b1);
		doReset();
		waitDone();
		prepare(m, 1'b0);
		doReset();
		waitDone();
		tallyAndFinish();
	end
endmodule // eeprom_config_loader_bench
`default_nettype wire
